/* File: dsr_regs.sv */
// Disk controller status and error register bank on AHB-Lite
`timescale 1ns/1ns
`include "dsr_consts.svh"
module dsr_regs (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Controller and drive levels
	input  wire logic        ctrl_busy,
	input  wire logic        drive_ready,
	input  wire logic        heads_settled,
	input  wire logic        xfer_ready,
	input  wire logic        index_pulse,
	// Controller and drive events
	input  wire logic        write_fault_evt,
	input  wire logic        corrected_evt,
	input  wire logic        bad_block_evt,
	input  wire logic        uncorrectable_evt,
	input  wire logic        id_missing_evt,
	input  wire logic        aborted_evt,
	input  wire logic        tk0_fail_evt,
	input  wire logic        tk0_found_evt,
	input  wire logic        cmd_start
);
	// ==========================================
	// Pin synchronisers
	logic [4:0] lvl_s1_q, lvl_s2_q, lvl_s1_d, lvl_s2_d;
	always_comb begin
		lvl_s1_d = {ctrl_busy, drive_ready, heads_settled, xfer_ready, index_pulse};
		lvl_s2_d = lvl_s1_q;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lvl_s1_q <= 5'h00;
			lvl_s2_q <= 5'h00;
		end else begin
			lvl_s1_q <= lvl_s1_d;
			lvl_s2_q <= lvl_s2_d;
		end
	end
	logic busy_s, drive_ready_flag_s, seek_s, xfer_s, index_s;
	assign {busy_s, drive_ready_flag_s, seek_s, xfer_s, index_s} = lvl_s2_q;

	// ==========================================
	// Bus front end
	logic        wr_en, rd_en;
	logic [11:0] reg_addr;
	dsr_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_en     (wr_en),
		.rd_en     (rd_en),
		.reg_addr  (reg_addr)
	);

	// ==========================================
	// Control register write decode (write 1 to clear)
	logic       ctl_wr;
	logic [2:0] clr_cmd;
	assign ctl_wr  = wr_en && (reg_addr == `DSR_OFF_CTRL);
	assign clr_cmd = ctl_wr ? hwdata[2:0] : `DSR_SET_RESET;

	// ==========================================
	// Error register: sticky, cleared on command start or by software
	logic [7:0] err_set, err_clr, err_flags;
	always_comb begin
		err_set = 8'h00;
		err_set[`DSR_ER_BADBLK] = bad_block_evt;
		err_set[`DSR_ER_UNC]    = uncorrectable_evt;
		err_set[`DSR_ER_IDMISS] = id_missing_evt;
		err_set[`DSR_ER_ABORT]  = aborted_evt;
		err_set[`DSR_ER_TK0]    = tk0_fail_evt;
		err_clr = {8{cmd_start || clr_cmd[`DSR_CT_CLR_ERR]}};
		err_clr[`DSR_ER_TK0] = err_clr[`DSR_ER_TK0] || tk0_found_evt;
	end
	dsr_event_flags #(.WIDTH(8)) u_err (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.set_in    (err_set),
		.clr_in    (err_clr),
		.keep_mask (`DSR_ER_USED),
		.flags     (err_flags)
	);

	// ==========================================
	// Status sticky bits: write fault, corrected data
	logic [1:0] st_set, st_clr, st_flags;
	always_comb begin
		st_set = {corrected_evt, write_fault_evt};
		st_clr = {clr_cmd[`DSR_CT_CLR_DATA_CORRECTED_FLAG] || cmd_start, clr_cmd[`DSR_CT_CLR_WF]};
	end
	dsr_event_flags #(.WIDTH(2)) u_st (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.set_in    (st_set),
		.clr_in    (st_clr),
		.keep_mask (2'h3),
		.flags     (st_flags)
	);

	// ==========================================
	// Status register assembly
	dsr_pkg::dsr_byte_t state_byte;
	always_comb begin
		state_byte = 8'h00;
		state_byte[`DSR_ST_READY]  = !busy_s;
		state_byte[`DSR_ST_DRIVE_READY_FLAG]   = drive_ready_flag_s;
		state_byte[`DSR_ST_WFAULT] = st_flags[0];
		state_byte[`DSR_ST_SEEK]   = seek_s;
		state_byte[`DSR_ST_XFER]   = xfer_s;
		state_byte[`DSR_ST_DATA_CORRECTED_FLAG]   = st_flags[1];
		state_byte[`DSR_ST_INDEX]  = index_s;
		state_byte[`DSR_ST_ERR]    = |err_flags;
	end

	// ==========================================
	// Read data, captured at the address phase, shown in the data phase
	function automatic logic [31:0] read_word(
		input logic [11:0] addr,
		input logic [7:0]  st,
		input logic [7:0]  er
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		case (addr)
			`DSR_OFF_STATE: word = {24'h000000, st};
			`DSR_OFF_FAULT: word = {24'h000000, er};
			`DSR_OFF_COMBO: word = {16'h0000, st, er};
			default:        word = 32'h0000_0000;
		endcase
		return word;
	endfunction
	logic        rd_take;
	logic [31:0] rdata_d, rdata_q;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_take) begin
			rdata_d = read_word(haddr, state_byte, err_flags);
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	// A flop drives hrdata, so it reads zero outside a read data phase
	assign hrdata = rdata_q;

	// ==========================================
	// Assertion sequences
	sequence s_rd_state;
		rd_en && (reg_addr == `DSR_OFF_STATE);
	endsequence
	sequence s_rd_fault;
		rd_en && (reg_addr == `DSR_OFF_FAULT);
	endsequence
	sequence s_rd_combo;
		rd_en && (reg_addr == `DSR_OFF_COMBO);
	endsequence
	sequence s_fault_written;
		wr_en && (reg_addr == `DSR_OFF_FAULT);
	endsequence
	sequence s_wf_cleared;
		clr_cmd[`DSR_CT_CLR_WF] && !write_fault_evt;
	endsequence
	sequence s_err_quiet;
		!bad_block_evt && !uncorrectable_evt && !id_missing_evt && !aborted_evt && !tk0_fail_evt && !tk0_found_evt;
	endsequence
	sequence s_err_cleared;
		(cmd_start || clr_cmd[`DSR_CT_CLR_ERR]) ##0 s_err_quiet;
	endsequence
	sequence s_err_kept;
		!cmd_start && !clr_cmd[`DSR_CT_CLR_ERR];
	endsequence

	// ==========================================
	// Status levels follow their pins two clocks later
	a_ready_low: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ctrl_busy) |-> ##2 !state_byte[`DSR_ST_READY])
		else $error("ready bit high while busy");
	a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(ctrl_busy) |-> ##2 state_byte[`DSR_ST_READY])
		else $error("ready bit low while idle");
	a_drive_ready_flag_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(drive_ready) |-> ##2 state_byte[`DSR_ST_DRIVE_READY_FLAG])
		else $error("drive ready lag");
	a_drive_ready_flag_drops: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(drive_ready) |-> ##2 !state_byte[`DSR_ST_DRIVE_READY_FLAG])
		else $error("drive ready stuck high");
	a_seek_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(heads_settled) |-> ##2 !state_byte[`DSR_ST_SEEK])
		else $error("seek bit lag");
	a_seek_rises: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(heads_settled) |-> ##2 state_byte[`DSR_ST_SEEK])
		else $error("seek bit stuck low");
	a_xfer_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(xfer_ready) |-> ##2 state_byte[`DSR_ST_XFER])
		else $error("transfer bit lag");
	a_xfer_drops: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(xfer_ready) |-> ##2 !state_byte[`DSR_ST_XFER])
		else $error("transfer bit stuck high");
	a_index_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(index_pulse) |-> ##2 state_byte[`DSR_ST_INDEX])
		else $error("index bit lag");
	a_index_drops: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(index_pulse) |-> ##2 !state_byte[`DSR_ST_INDEX])
		else $error("index bit stuck high");

	// ==========================================
	// Sticky status bits
	a_wf_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		write_fault_evt |=> state_byte[`DSR_ST_WFAULT])
		else $error("write fault not set");
	a_wf_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wf_cleared |=> !state_byte[`DSR_ST_WFAULT])
		else $error("write fault not cleared");
	a_wf_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		state_byte[`DSR_ST_WFAULT] && !clr_cmd[`DSR_CT_CLR_WF] |=> state_byte[`DSR_ST_WFAULT])
		else $error("write fault lost");
	a_data_corrected_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		corrected_evt |=> state_byte[`DSR_ST_DATA_CORRECTED_FLAG])
		else $error("corrected bit not set");
	a_data_corrected_flag_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmd_start || clr_cmd[`DSR_CT_CLR_DATA_CORRECTED_FLAG]) && !corrected_evt |=> !state_byte[`DSR_ST_DATA_CORRECTED_FLAG])
		else $error("corrected bit not cleared");
	a_data_corrected_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		state_byte[`DSR_ST_DATA_CORRECTED_FLAG] && !cmd_start && !clr_cmd[`DSR_CT_CLR_DATA_CORRECTED_FLAG] |=> state_byte[`DSR_ST_DATA_CORRECTED_FLAG])
		else $error("corrected bit lost");

	// ==========================================
	// Error register
	a_err_summary: assert property (@(posedge hclk) disable iff (!hresetn)
		aborted_evt |=> state_byte[`DSR_ST_ERR])
		else $error("error summary not set");
	a_err_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		s_err_cleared |=> !state_byte[`DSR_ST_ERR])
		else $error("error summary not cleared");
	a_abort_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		aborted_evt |=> err_flags[`DSR_ER_ABORT])
		else $error("abort not reported");
	a_abort_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		err_flags[`DSR_ER_ABORT] ##0 s_err_kept |=> err_flags[`DSR_ER_ABORT])
		else $error("abort flag lost");
	a_badblk_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		bad_block_evt |=> err_flags[`DSR_ER_BADBLK])
		else $error("bad block not set");
	a_badblk_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		err_flags[`DSR_ER_BADBLK] ##0 s_err_kept |=> err_flags[`DSR_ER_BADBLK])
		else $error("bad block flag lost");
	a_unc_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		uncorrectable_evt |=> err_flags[`DSR_ER_UNC])
		else $error("uncorrectable not set");
	a_unc_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		err_flags[`DSR_ER_UNC] ##0 s_err_kept |=> err_flags[`DSR_ER_UNC])
		else $error("uncorrectable flag lost");
	a_idmiss_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		id_missing_evt |=> err_flags[`DSR_ER_IDMISS])
		else $error("id missing not set");
	a_idmiss_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		err_flags[`DSR_ER_IDMISS] ##0 s_err_kept |=> err_flags[`DSR_ER_IDMISS])
		else $error("id missing flag lost");
	a_tk0_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		tk0_fail_evt |=> err_flags[`DSR_ER_TK0])
		else $error("track zero failure not set");
	a_tk0_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		tk0_found_evt && !tk0_fail_evt |=> !err_flags[`DSR_ER_TK0])
		else $error("track zero flag stuck");
	a_tk0_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(err_flags[`DSR_ER_TK0] && !tk0_found_evt) ##0 s_err_kept |=> err_flags[`DSR_ER_TK0])
		else $error("track zero flag lost");
	a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(err_flags & ~`DSR_ER_USED) == 8'h00)
		else $error("unused error bits set");
	a_fault_ro: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fault_written ##0 s_err_quiet ##0 s_err_kept |=> err_flags == $past(err_flags))
		else $error("error register changed by a write");

	// ==========================================
	// Read path
	a_rd_state: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd_state |-> hrdata == {24'h000000, $past(state_byte)})
		else $error("status read wrong");
	a_rd_fault: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd_fault |-> hrdata == {24'h000000, $past(err_flags)})
		else $error("error register read wrong");
	a_rd_combo: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd_combo |-> hrdata == {16'h0000, $past(state_byte), $past(err_flags)})
		else $error("combined read wrong");
endmodule

/* File: dsr_consts.svh */
// Constants for the disk controller status and error register bank
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH
// ==========================================
// Register byte addresses
`define DSR_OFF_STATE   12'h000
`define DSR_OFF_FAULT   12'h004
`define DSR_OFF_CTRL    12'h008
`define DSR_OFF_COMBO   12'h00C
// ==========================================
// Status bit positions
`define DSR_ST_READY    7
`define DSR_ST_DRIVE_READY_FLAG     6
`define DSR_ST_WFAULT   5
`define DSR_ST_SEEK     4
`define DSR_ST_XFER     3
`define DSR_ST_DATA_CORRECTED_FLAG     2
`define DSR_ST_INDEX    1
`define DSR_ST_ERR      0
// ==========================================
// Error bit positions
`define DSR_ER_BADBLK   7
`define DSR_ER_UNC      6
`define DSR_ER_IDMISS   4
`define DSR_ER_ABORT    2
`define DSR_ER_TK0      1
`define DSR_ER_USED     8'hD6
// ==========================================
// Control bit positions and reset values
`define DSR_CT_CLR_ERR  0
`define DSR_CT_CLR_DATA_CORRECTED_FLAG 1
`define DSR_CT_CLR_WF   2
`define DSR_ERR_RESET   8'h00
`define DSR_SET_RESET   3'h0
`endif

/* File: dsr_pkg.sv */
// Types shared by the disk controller register bank
package dsr_pkg;
	typedef enum logic [1:0] {
		DSR_IDLE = 2'b00,
		DSR_DATA = 2'b01
	} dsr_phase_e;
	typedef logic [7:0] dsr_byte_t;
endpackage

/* File: dsr_ahb_slave.sv */
// AHB-Lite slave front end with a one-cycle registered data phase
`timescale 1ns/1ns
`include "dsr_consts.svh"
module dsr_ahb_slave (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave side
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	// Register side
	output logic             wr_en,
	output logic             rd_en,
	output logic [11:0]      reg_addr
);
	// ==========================================
	// Address phase capture
	logic        act_d, act_q, wr_d, wr_q;
	logic [11:0] addr_d, addr_q;
	always_comb begin
		act_d  = hsel && hready && htrans[1];
		wr_d   = hwrite;
		addr_d = haddr;
		if (!(hsel && hready)) begin
			wr_d   = wr_q;
			addr_d = addr_q;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_q  <= 1'b0;
			wr_q   <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			act_q  <= act_d;
			wr_q   <= wr_d;
			addr_q <= addr_d;
		end
	end
	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_en     = act_q && wr_q;
	assign rd_en     = act_q && !wr_q;
	assign reg_addr  = addr_q;
endmodule

/* File: dsr_event_flags.sv */
// Sticky flag bank: hardware set wins over software clear
`timescale 1ns/1ns
module dsr_event_flags #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Events and clears
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clr_in,
	input  wire logic [WIDTH-1:0] keep_mask,
	output logic      [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] flag_d, flag_q;
	always_comb begin
		flag_d = ((flag_q & ~clr_in) | set_in) & keep_mask;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign flags = flag_q;
endmodule

/* File: dsr_host_model.sv */
// Host processor model: single-word AHB-Lite master and status report
`timescale 1ns/1ns
module dsr_host_model (
	// Clock
	input  wire logic        hclk,
	// AHB-Lite master side
	output logic             hsel,
	output logic [11:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	logic tmo;
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, tmo} = '0;
		hsize = 3'h2;
	end
	// ==========================================
	// One transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
		tmo = tmo | (n >= 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= wd;
		n = 0;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
		tmo = tmo | (n >= 50);
		rd = hrdata;
		hwdata <= ~wd;
	endtask
	// ==========================================
	// Two-byte report: status high, error low
	task automatic report(output logic [15:0] code);
		logic [31:0] s;
		logic [31:0] e;
		xfer(1'b0, 12'h000, 32'h0, s);
		xfer(1'b0, 12'h004, 32'h0, e);
		code = {s[7:0], e[7:0]};
	endtask
endmodule

/* File: test_disk_ctrl_status_error_regs.sv */
// Self-checking bench for the disk controller status and error registers
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_disk_ctrl_status_error_regs;
	typedef struct packed {logic [4:0] lv; logic [6:0] ev; logic [7:0] st; logic [7:0] er;} dsr_row_s;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, d;
	logic [15:0] code;
	logic        busy, drive_ready_flag, seek, xrdy, idx, wf, data_corrected_flag, bad, uncorrectable_flag, idm, command_aborted_flag, tk0f, tk0ok, cst;
	int          mismatches, n_checks;
	dsr_row_s    rows [13];
	dsr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ctrl_busy(busy), .drive_ready(drive_ready_flag), .heads_settled(seek),
		.xfer_ready(xrdy), .index_pulse(idx), .write_fault_evt(wf), .corrected_evt(data_corrected_flag),
		.bad_block_evt(bad), .uncorrectable_evt(uncorrectable_flag), .id_missing_evt(idm), .aborted_evt(command_aborted_flag),
		.tk0_fail_evt(tk0f), .tk0_found_evt(tk0ok), .cmd_start(cst));
	dsr_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
	// ==========================================
	// Clock and helpers
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic final_report();
		if (mismatches == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd);
		host.xfer(w, a, wd, d);
		if (host.tmo) begin mismatches++; final_report(); end
	endtask
	task automatic pulse(input logic [7:0] v);
		{wf, data_corrected_flag, bad, uncorrectable_flag, idm, command_aborted_flag, tk0f, cst} <= v;
		@(posedge hclk);
		{wf, data_corrected_flag, bad, uncorrectable_flag, idm, command_aborted_flag, tk0f, cst} <= 8'h00;
		repeat (3) @(posedge hclk);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{busy, drive_ready_flag, seek, xrdy, idx, wf, data_corrected_flag, bad, uncorrectable_flag, idm, command_aborted_flag, tk0f, tk0ok, cst} = '0;
		{mismatches, n_checks} = '0;
		hresetn = 1'b0;
		rows = '{{5'h00, 7'h00, 8'h80, 8'h00}, {5'h10, 7'h00, 8'h00, 8'h00}, {5'h08, 7'h00, 8'hC0, 8'h00},
			{5'h04, 7'h00, 8'h90, 8'h00}, {5'h02, 7'h00, 8'h88, 8'h00}, {5'h01, 7'h00, 8'h82, 8'h00},
			{5'h00, 7'h40, 8'hA0, 8'h00}, {5'h00, 7'h20, 8'h84, 8'h00}, {5'h00, 7'h10, 8'h81, 8'h80},
			{5'h00, 7'h08, 8'h81, 8'h40}, {5'h00, 7'h04, 8'h81, 8'h10}, {5'h00, 7'h02, 8'h81, 8'h04},
			{5'h00, 7'h01, 8'h81, 8'h02}};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		acc(1'b0, 12'h004, 32'h0);
		`CHK(d, 32'h0000_0000)
		foreach (rows[i]) begin
			{busy, drive_ready_flag, seek, xrdy, idx} <= rows[i].lv;
			pulse({rows[i].ev, 1'b0});
			acc(1'b0, 12'h00C, 32'h0);
			`CHK(d, {16'h0000, rows[i].st, rows[i].er})
			host.report(code);
			`CHK(code, {rows[i].st, rows[i].er})
			acc(1'b1, 12'h008, 32'h0000_0007);
		end
		// Read-only error register and unmapped place
		pulse(8'h3C);
		acc(1'b1, 12'h004, 32'hFFFF_FFFF);
		acc(1'b0, 12'h004, 32'h0);
		`CHK(d, 32'h0000_00D4)
		`CHK({hreadyout, hresp}, 2'b10)
		acc(1'b0, 12'h010, 32'h0);
		`CHK(d, 32'h0000_0000)
		// Command start clears errors and correction but keeps the write fault
		pulse(8'hC0);
		pulse(8'h01);
		acc(1'b0, 12'h00C, 32'h0);
		`CHK(d, 32'h0000_A000)
		acc(1'b1, 12'h008, 32'h0000_0003);
		acc(1'b0, 12'h000, 32'h0);
		`CHK(d, 32'h0000_00A0)
		// Track zero found clears the recalibrate failure
		pulse(8'h02);
		tk0ok <= 1'b1;
		@(posedge hclk);
		tk0ok <= 1'b0;
		acc(1'b0, 12'h00C, 32'h0);
		`CHK(d, 32'h0000_A000)
		// Event and command start in one cycle: the event wins
		pulse(8'h05);
		acc(1'b0, 12'h00C, 32'h0);
		`CHK(d, 32'h0000_A104)
		// Reset in mid-run clears every flag
		pulse(8'h20);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		acc(1'b0, 12'h00C, 32'h0);
		`CHK(d, 32'h0000_8000)
		final_report();
	end
endmodule
